// ==== hdl/cgcr_defs.svh ====
// Constants for the chip setup and strap status register block.
`ifndef CGCR_DEFS_SVH
`define CGCR_DEFS_SVH
`define CGCR_IDX_SETUP        8'h02
`define CGCR_BIT_UNUSED       7
`define CGCR_BIT_VOLT         6
`define CGCR_BIT_MODE_HI      5
`define CGCR_BIT_MODE_LO      4
`define CGCR_BIT_PORT_SEL     3
`define CGCR_BIT_CLK_OFF      0
`define CGCR_RST_INDEX        8'h00
`define CGCR_RST_CLK_OFF      1'b0
`define CGCR_RST_MODE         2'h0
`endif

// ==== hdl/cgcr_pkg.sv ====
// Types for the chip setup and strap status register block.
package cgcr_pkg;
    typedef enum logic [1:0] {
        CGCR_SOFT_BOARD    = 2'h0,
        CGCR_SOFT_CARD     = 2'h1,
        CGCR_STRAP_EXT     = 2'h2,
        CGCR_STRAP_BASIC   = 2'h3
    } cgcr_mode_t;
    typedef enum {
        CGCR_ST_CAPTURE,
        CGCR_ST_RUN
    } cgcr_state_t;
endpackage

// ==== hdl/cgcr_strap_latch.sv ====
// Captures strap levels once after reset release.
`timescale 1ns/100ps
`include "cgcr_defs.svh"
module cgcr_strap_latch
    import cgcr_pkg::*;
#(
    parameter int WIDTH = 5
) (
    // Clock and reset.
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Strap levels and captured copy.
    input  wire logic [WIDTH-1:0] i_straps,
    output logic      [WIDTH-1:0] o_straps,
    output logic                  o_valid
);
    // ----------------------------------------
    // Capture
    // ----------------------------------------
    // Reset loads constants only; the straps are taken at the first edge after release.
    cgcr_state_t      state_q;
    logic [WIDTH-1:0] straps_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q  <= CGCR_ST_CAPTURE;
            straps_q <= '0;
        end else begin
            case (state_q)
                CGCR_ST_CAPTURE: begin
                    straps_q <= i_straps;
                    state_q  <= CGCR_ST_RUN;
                end
                CGCR_ST_RUN: begin
                    state_q <= CGCR_ST_RUN;
                end
                default: begin
                    state_q <= CGCR_ST_CAPTURE;
                end
            endcase
        end
    end
    assign o_straps = straps_q;
    assign o_valid  = (state_q == CGCR_ST_RUN);
endmodule

// ==== hdl/cgcr_top.sv ====
// Chip setup and strap status register reached through an index and data port pair.
`timescale 1ns/100ps
`include "cgcr_defs.svh"
module cgcr_top
    import cgcr_pkg::*;
(
    // Host bus clock and hard reset.
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Index and data port access strobes, one cycle each.
    input  wire logic       i_index_wr,
    input  wire logic       i_data_wr,
    input  wire logic       i_data_rd,
    input  wire logic [7:0] i_wdata,
    // Strap levels.
    input  wire logic       i_strap_volt_3v3,
    input  wire logic [1:0] i_strap_mode,
    input  wire logic       i_strap_port_sec,
    input  wire logic       i_strap_lockout,
    // Peripheral powerdown states, which must not touch the clock.
    input  wire logic       i_auto_powerdown,
    input  wire logic       i_cmd_powerdown,
    // Read data and control outputs.
    output logic      [7:0] o_rdata,
    output logic            o_rdata_valid,
    output logic      [7:0] o_index,
    output logic            o_main_clock_off,
    output cgcr_mode_t      o_config_mode
);
    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    logic [4:0] straps;
    logic       straps_valid;
    cgcr_strap_latch #(.WIDTH(5)) u_straps (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_straps ({i_strap_lockout, i_strap_port_sec, i_strap_mode, i_strap_volt_3v3}),
        .o_straps (straps),
        .o_valid  (straps_valid)
    );
    wire logic       strap_volt   = straps[0];
    wire logic [1:0] strap_mode   = straps[2:1];
    wire logic       strap_sec    = straps[3];
    wire logic       strap_locked = straps[4];

    // ----------------------------------------
    // Index port and decode
    // ----------------------------------------
    logic [7:0] index_q;
    logic [7:0] index_d;
    assign index_d = i_index_wr ? i_wdata : index_q;
    a_index_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_index_wr |=> o_index == $past(i_wdata))
        else $error("Index write not latched.");
    a_index_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_index_wr |=> $stable(o_index))
        else $error("Index changed without an index write.");
    a_data_keeps_index: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_data_wr || i_data_rd) && !i_index_wr |=> $stable(o_index))
        else $error("Data port access moved the index.");
    wire logic hit     = (index_q == `CGCR_IDX_SETUP);
    wire logic wr_hit  = i_data_wr && hit && straps_valid;
    wire logic mode_we = wr_hit && !strap_locked;

    // ----------------------------------------
    // Register fields
    // ----------------------------------------
    // This logic runs on the bus clock, never on the gated main clock, so software can always undo a shutdown.
    logic [1:0] mode_q;
    logic       mode_init_q;
    logic       clk_off_q;
    logic [1:0] mode_d;
    logic       clk_off_d;
    assign mode_d    = !mode_init_q && straps_valid ? strap_mode
                     : mode_we ? i_wdata[`CGCR_BIT_MODE_HI:`CGCR_BIT_MODE_LO]
                     : mode_q;
    assign clk_off_d = wr_hit ? i_wdata[`CGCR_BIT_CLK_OFF] : clk_off_q;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            index_q     <= `CGCR_RST_INDEX;
            mode_q      <= `CGCR_RST_MODE;
            mode_init_q <= 1'b0;
            clk_off_q   <= `CGCR_RST_CLK_OFF;
        end else begin
            index_q     <= index_d;
            mode_q      <= mode_d;
            mode_init_q <= mode_init_q | straps_valid;
            clk_off_q   <= clk_off_d;
        end
    end

    // ----------------------------------------
    // Field checks
    // ----------------------------------------
    a_read_no_side: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && !i_data_wr |=> $stable(clk_off_q))
        else $error("A read changed the clock shutdown bit.");
    a_mode_no_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        mode_init_q && !mode_we |=> $stable(mode_q))
        else $error("Mode changed without an allowed write.");
    a_clock_no_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !wr_hit |=> $stable(clk_off_q))
        else $error("Clock shutdown bit changed without a write.");

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Bit 7 and reserved bits 2:1 read as zero; bit 6 and bit 3 come from straps only.
    logic [7:0] reg_view;
    assign reg_view = {1'b0,
                       strap_volt,
                       mode_q,
                       strap_sec,
                       2'h0,
                       clk_off_q};
    wire logic [7:0] rd_mux = hit ? reg_view : 8'h00;

    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       clk_out_q;
    logic [1:0] mode_out_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q    <= 8'h00;
            rvalid_q   <= 1'b0;
            clk_out_q  <= `CGCR_RST_CLK_OFF;
            mode_out_q <= `CGCR_RST_MODE;
        end else begin
            rdata_q    <= i_data_rd ? rd_mux : rdata_q;
            rvalid_q   <= i_data_rd;
            clk_out_q  <= clk_off_d;
            mode_out_q <= mode_d;
        end
    end
    assign o_rdata          = rdata_q;
    assign o_rdata_valid    = rvalid_q;
    assign o_index          = index_q;
    assign o_main_clock_off = clk_out_q;
    assign o_config_mode    = cgcr_mode_t'(mode_out_q);

    // ----------------------------------------
    // Read and output checks
    // ----------------------------------------
    a_rvalid_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd |=> o_rdata_valid)
        else $error("Read answer missing.");
    a_rvalid_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_data_rd |=> !o_rdata_valid)
        else $error("Read answer without a read.");
    a_rdata_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_data_rd |=> $stable(o_rdata))
        else $error("Read data changed without a read.");
    a_rdata_from_view: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && hit |=> o_rdata == $past(reg_view))
        else $error("Read data does not match the register.");
    a_other_index_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && !hit |=> o_rdata == 8'h00)
        else $error("Another index read nonzero.");
    a_volt_write_ignored: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_hit |=> reg_view[6] == $past(reg_view[6]))
        else $error("Voltage flag moved on a write.");
    a_port_read_only: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_hit |=> reg_view[3] == $past(reg_view[3]))
        else $error("Port select flag moved on a write.");
    a_unused_view: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        reg_view[7] == 1'b0 && reg_view[2:1] == 2'h0)
        else $error("Unused bits of the register are nonzero.");
    a_mode_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && hit |=> o_rdata[5:4] == $past(mode_q))
        else $error("Mode field read wrong.");
    a_mode_mirror: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_config_mode == cgcr_mode_t'(mode_q))
        else $error("Mode output differs from the field.");
    a_clock_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && hit |=> o_rdata[0] == $past(clk_off_q))
        else $error("Clock shutdown bit read wrong.");
    a_clock_mirror: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_main_clock_off == clk_off_q)
        else $error("Clock shutdown output differs from the field.");

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_volt_read_only: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        straps_valid && $past(straps_valid) |-> reg_view[6] == $past(reg_view[6]))
        else $error("Voltage flag changed after strap capture.");
    a_unused_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_rdata_valid |-> o_rdata[7] == 1'b0 && o_rdata[2:1] == 2'h0)
        else $error("Unused bits read nonzero.");
    a_volt_reports: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && hit |=> o_rdata[6] == strap_volt)
        else $error("Voltage flag does not match strap.");
    a_port_reports: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_rd && hit |=> o_rdata[3] == strap_sec)
        else $error("Port select flag does not match strap.");
    a_mode_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        mode_we && mode_init_q |=> o_config_mode == cgcr_mode_t'($past(i_wdata[5:4])))
        else $error("Mode write not applied.");
    a_mode_locked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        strap_locked && mode_init_q |=> mode_q == $past(mode_q))
        else $error("Mode changed while locked out.");
    a_mode_from_strap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        straps_valid && !mode_init_q |=> mode_q == $past(strap_mode))
        else $error("Mode did not start from straps.");
    a_clock_follows: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_hit |=> o_main_clock_off == $past(i_wdata[0]))
        else $error("Clock shutdown output did not follow write.");
    a_clock_alone: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !wr_hit && (i_auto_powerdown || i_cmd_powerdown) |=> $stable(o_main_clock_off))
        else $error("Clock shutdown moved without a register write.");
    a_index_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_data_wr && !hit |=> $stable(clk_off_q))
        else $error("Write to another index reached this register.");
endmodule

// ==== testbench/cgcr_host_model.sv ====
// Host model that reaches the register through the index and data port pair.
`timescale 1ns/100ps
module cgcr_host_model (
    // Clock and read answer from the register block.
    input  wire logic       i_clock,
    input  wire logic       i_rdata_valid,
    input  wire logic [7:0] i_rdata,
    // Port strobes and write data towards the register block.
    output logic            o_index_wr,
    output logic            o_data_wr,
    output logic            o_data_rd,
    output logic      [7:0] o_wdata
);
    // ----------------------------------------
    // Port cycles
    // ----------------------------------------
    initial begin
        o_index_wr = 1'b0;
        o_data_wr  = 1'b0;
        o_data_rd  = 1'b0;
        o_wdata    = 8'h5a;
    end
    // One strobe for one cycle; the data lines then carry the inverse so stale data is never reused.
    task automatic put(input logic iw, input logic dw, input logic dr, input logic [7:0] v);
        @(posedge i_clock);
        {o_index_wr, o_data_wr, o_data_rd, o_wdata} <= {iw, dw, dr, v};
        @(posedge i_clock);
        {o_index_wr, o_data_wr, o_data_rd, o_wdata} <= {3'h0, ~v};
    endtask
    task automatic sel(input logic [7:0] idx);
        put(1'b1, 1'b0, 1'b0, idx);
    endtask
    task automatic wr(input logic [7:0] v);
        put(1'b0, 1'b1, 1'b0, v & 8'h7f);
    endtask
    task automatic rd(output logic [7:0] v);
        v = 8'hxx;
        put(1'b0, 1'b0, 1'b1, 8'h00);
        for (int n = 0; n < 4; n++) begin
            @(negedge i_clock);
            if (i_rdata_valid === 1'b1) begin
                v = i_rdata;
                break;
            end
        end
    endtask
    // Only the masked fields change; reserved positions go back as they were read.
    task automatic rmw(input logic [7:0] mask, input logic [7:0] v);
        logic [7:0] old;
        rd(old);
        wr((old & ~mask) | (v & mask));
    endtask
endmodule

// ==== testbench/tb_chip_global_config_register.sv ====
// Self-checking testbench for the chip setup and strap status register.
`timescale 1ns/100ps
module tb_chip_global_config_register;
    import cgcr_pkg::*;
    logic       i_clock, i_rst_n, index_wr, data_wr, data_rd, o_rdata_valid, o_main_clock_off;
    logic       volt, port_sec, lockout, auto_pd, cmd_pd;
    logic [1:0] smode, m;
    logic [7:0] wdata, o_rdata, o_index, got, expv;
    cgcr_mode_t o_config_mode;
    int         mismatches, checks_done;
    cgcr_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_index_wr(index_wr), .i_data_wr(data_wr),
        .i_data_rd(data_rd), .i_wdata(wdata), .i_strap_volt_3v3(volt), .i_strap_mode(smode),
        .i_strap_port_sec(port_sec), .i_strap_lockout(lockout), .i_auto_powerdown(auto_pd),
        .i_cmd_powerdown(cmd_pd), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
        .o_index(o_index), .o_main_clock_off(o_main_clock_off), .o_config_mode(o_config_mode));
    cgcr_host_model host (.i_clock(i_clock), .i_rdata_valid(o_rdata_valid), .i_rdata(o_rdata),
        .o_index_wr(index_wr), .o_data_wr(data_wr), .o_data_rd(data_rd), .o_wdata(wdata));
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
    endtask
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    // The whole run is about a hundred cycles, so this span only trips on a hang.
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial begin
        {i_rst_n, volt, port_sec, lockout, auto_pd, cmd_pd, smode} = 8'h00;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            {volt, smode, port_sec, lockout, auto_pd, cmd_pd} <= {m[0], m, m[1], m[0], m[1], ~m[0]};
            do_reset();
            host.sel(8'h02);
            host.rd(got);
            check(got, {1'b0, m[0], m, m[1], 3'h0});
            check({6'h00, o_config_mode}, {6'h00, m});
            host.wr({1'b0, ~m[0], ~m, ~m[1], 3'h7});
            auto_pd <= ~auto_pd;
            cmd_pd <= ~cmd_pd;
            host.rd(got);
            expv = {1'b0, m[0], (m[0] ? m : ~m), m[1], 3'h1};
            check(got, expv);
            check({7'h00, o_main_clock_off}, 8'h01);
            check({6'h00, o_config_mode}, {6'h00, expv[5:4]});
            host.rmw(8'h01, 8'h00);
            host.rd(got);
            check(got, expv & 8'hfe);
            check({7'h00, o_main_clock_off}, 8'h00);
            $display("strap set %0d done", i);
            @(posedge i_clock);
        end
        host.sel(8'h03);
        @(negedge i_clock);
        check(o_index, 8'h03);
        host.wr(8'h01);
        host.rd(got);
        check(got, 8'h00);
        check({7'h00, o_main_clock_off}, 8'h00);
        $display("other index test done");
        end_sim();
    end
endmodule
